// ==== hdl/flrwl_top.sv ====
// Flash row write latch sequencer: unlock, latch load, commit, erase
// Assumes one CPU instruction per clock and a flash macro that
// answers each request with a one-cycle done pulse
//
// Behaviour
// [R1] A program operation never erases first; it writes onto blank words
// [R2] Erase works on a whole row, never on one word
// [R3] Sixteen write latches; one to sixteen loads per commit
// [R4] Row from upper ten address bits; latch from low bits
// [R5] Latch index wraps inside the row, never into the next row
// [R6] All latches return to 3FFFh when any operation completes
// [R7] Latches left unloaded stay blank through a commit
// [R8] Latch-only mode: unlock loads one latch, no flash write
// [R9] Commit mode: unlock loads the word, then programs the row
// [R10] Nothing starts without a complete, uninterrupted unlock
// [R11] Software sets write enable and clears config select first
// [R12] Software loads address, data, unlock, increments, repeats
// [R13] Software keeps interrupts off across the sequences
// [R14] Unlock is 55h, 0AAh to unlock port, then start bit
// [R15] Two forced no-ops after start, then stall until done
// [R16] Latch word is low data byte plus six high bits
// [R17] Unlock ignored without write enable; start bit self-clears
`timescale 1ns/1ps
`default_nettype none
`include "flrwl_cfg.svh"

module flrwl_top #(
    parameter int LATCH_NUM = `FLRWL_LATCH_NUM,
    parameter int WORD_W = `FLRWL_WORD_W,
    parameter int IDX_W = `FLRWL_IDX_W
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rstn_i,
    // Address and data register pairs
    input wire flrwl_pkg::flrwl_addr_s prog_addr_i,
    input wire flrwl_pkg::flrwl_data_s prog_data_i,
    // Control bits
    input wire logic write_enable_bit_i,
    input wire logic config_space_select_i,
    input wire logic latch_only_mode_i,
    input wire logic erase_select_i,
    // CPU strobes
    input wire logic unlock_wr_i,
    input wire logic [7:0] unlock_data_i,
    input wire logic other_wr_i,
    input wire logic write_start_set_i,
    // CPU status
    output logic write_start_o,
    output logic force_nop_o,
    output logic cpu_stall_o,
    // Flash macro
    output logic flash_req_o,
    output flrwl_pkg::flrwl_flash_req_s flash_cmd_o,
    output logic [LATCH_NUM-1:0][WORD_W-1:0] flash_words_o,
    input wire logic flash_done_i
);

    flrwl_pkg::flrwl_seq_e state_q, state_d;
    flrwl_pkg::flrwl_flash_req_s cmd_q, cmd_d;
    logic busy_q, busy_d;
    logic req_q, req_d;
    logic fire;
    logic load_now;
    logic blank_now;
    logic [IDX_W-1:0] latch_idx;
    logic [WORD_W-1:0] latch_word;
    logic [`FLRWL_ROW_W-1:0] row_sel;

    // Row part of the address pair
    function automatic logic [`FLRWL_ROW_W-1:0] row_of(
        input flrwl_pkg::flrwl_addr_s a
    );
        logic [`FLRWL_ADDR_W-1:0] flat;
        flat = {a.addr_high, a.addr_low};
        row_of = flat[`FLRWL_ADDR_W-1:`FLRWL_ROW_LSB];
    endfunction

    // Latch part of the address pair
    function automatic logic [IDX_W-1:0] idx_of(
        input flrwl_pkg::flrwl_addr_s a
    );
        idx_of = a.addr_low[IDX_W-1:0];
    endfunction

    // Latch word from the data pair
    function automatic logic [WORD_W-1:0] word_of(
        input flrwl_pkg::flrwl_data_s d
    );
        word_of = {d.data_high[WORD_W-9:0], d.data_low};
    endfunction

    // [R14] Sequence detector
    flrwl_unlock u_unlock (
        .clk_i(clk_i),
        .rstn_i(rstn_i),
        .unlock_wr_i(unlock_wr_i),
        .unlock_data_i(unlock_data_i),
        .other_wr_i(other_wr_i),
        .start_i(write_start_set_i && !busy_q),
        .write_enable_bit_i(write_enable_bit_i),
        .fire_o(fire)
    );

    // [R4] Address split
    // [R5] Index cannot leave the row
    assign row_sel = row_of(prog_addr_i);
    assign latch_idx = idx_of(prog_addr_i);
    // [R16] Word forming
    assign latch_word = word_of(prog_data_i);

    // [R8] Latch load on unlock
    // [R9] Commit also loads first
    assign load_now = fire && !erase_select_i;
    // [R6] Blank on completion
    assign blank_now = req_q && flash_done_i;

    // [R3] Sixteen latches
    flrwl_latches #(
        .LATCH_NUM(LATCH_NUM),
        .WORD_W(WORD_W),
        .IDX_W(IDX_W)
    ) u_latches (
        .clk_i(clk_i),
        .rstn_i(rstn_i),
        .load_i(load_now),
        .idx_i(latch_idx),
        .word_i(latch_word),
        .blank_i(blank_now),
        .words_o(flash_words_o)
    );

    always_comb begin
        state_d = state_q;
        cmd_d = cmd_q;
        busy_d = busy_q;
        req_d = req_q;
        case (state_q)
            flrwl_pkg::FLRWL_SQ_IDLE: begin
                // [R10] Only a full unlock starts
                if (fire) begin
                    busy_d = 1'b1;
                    state_d = flrwl_pkg::FLRWL_SQ_NOP1;
                    cmd_d.row = row_sel;
                    cmd_d.cfg = config_space_select_i;
                    // [R1] Program never erases
                    // [R2] Erase is row-wide
                    if (erase_select_i) begin
                        cmd_d.op = flrwl_pkg::FLRWL_OP_ERASE;
                    end else if (latch_only_mode_i) begin
                        cmd_d.op = flrwl_pkg::FLRWL_OP_NONE;
                    end else begin
                        cmd_d.op = flrwl_pkg::FLRWL_OP_PROG;
                    end
                end
            end
            flrwl_pkg::FLRWL_SQ_NOP1: begin
                state_d = flrwl_pkg::FLRWL_SQ_NOP2;
            end
            flrwl_pkg::FLRWL_SQ_NOP2: begin
                // [R17] Start bit clears after load
                if (cmd_q.op == flrwl_pkg::FLRWL_OP_NONE) begin
                    busy_d = 1'b0;
                    state_d = flrwl_pkg::FLRWL_SQ_IDLE;
                end else begin
                    req_d = 1'b1;
                    state_d = flrwl_pkg::FLRWL_SQ_WAIT;
                end
            end
            flrwl_pkg::FLRWL_SQ_WAIT: begin
                // [R15] Stall until done
                if (flash_done_i) begin
                    req_d = 1'b0;
                    busy_d = 1'b0;
                    state_d = flrwl_pkg::FLRWL_SQ_IDLE;
                end
            end
            default: begin
                state_d = flrwl_pkg::FLRWL_SQ_IDLE;
                busy_d = 1'b0;
                req_d = 1'b0;
            end
        endcase
    end

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            state_q <= flrwl_pkg::FLRWL_SQ_IDLE;
            cmd_q <= '0;
            busy_q <= 1'b0;
            req_q <= 1'b0;
        end else begin
            state_q <= state_d;
            cmd_q <= cmd_d;
            busy_q <= busy_d;
            req_q <= req_d;
        end
    end

    // [R15] Forced no-ops, then stall
    assign force_nop_o = (state_q == flrwl_pkg::FLRWL_SQ_NOP1) ||
                         (state_q == flrwl_pkg::FLRWL_SQ_NOP2);
    assign cpu_stall_o = (state_q == flrwl_pkg::FLRWL_SQ_WAIT);
    assign write_start_o = busy_q;
    assign flash_req_o = req_q;
    assign flash_cmd_o = cmd_q;

    // Checks

    prog_no_erase_a: assert property ( // [R1]
        @(posedge clk_i) disable iff (!rstn_i)
        (fire && !erase_select_i && !latch_only_mode_i)
            |-> ##3 (flash_req_o &&
                     flash_cmd_o.op == flrwl_pkg::FLRWL_OP_PROG)
    ) else $error("Commit did not issue a plain program");

    erase_keeps_latches_a: assert property ( // [R2]
        @(posedge clk_i) disable iff (!rstn_i)
        (fire && erase_select_i) |=> $stable(flash_words_o)
    ) else $error("Erase start touched a latch");

    row_capture_a: assert property ( // [R4]
        @(posedge clk_i) disable iff (!rstn_i)
        fire |=> flash_cmd_o.row ==
            $past({prog_addr_i.addr_high, prog_addr_i.addr_low[7:5]})
    ) else $error("Row not taken from upper address bits");

    latch_wrap_a: assert property ( // [R5]
        @(posedge clk_i) disable iff (!rstn_i)
        (load_now && latch_idx == {IDX_W{1'b1}}) |=>
            flash_words_o[0] == $past(flash_words_o[0])
    ) else $error("Last latch load spilled into latch zero");

    blank_done_a: assert property ( // [R6]
        @(posedge clk_i) disable iff (!rstn_i)
        (flash_req_o && flash_done_i) |=>
            flash_words_o == {LATCH_NUM{WORD_W'(`FLRWL_BLANK)}}
    ) else $error("Latches not blank after operation");

    latch_load_a: assert property ( // [R8]
        @(posedge clk_i) disable iff (!rstn_i)
        (fire && latch_only_mode_i && !erase_select_i) |=>
            flash_words_o[$past(latch_idx)] == $past(latch_word)
            && !flash_req_o
    ) else $error("Latch-only unlock did not load one latch");

    commit_start_a: assert property ( // [R9]
        @(posedge clk_i) disable iff (!rstn_i)
        (fire && !latch_only_mode_i && !erase_select_i) |=>
            flash_words_o[$past(latch_idx)] == $past(latch_word)
            ##2 flash_req_o
    ) else $error("Commit did not load then program");

    idle_hold_a: assert property ( // [R10]
        @(posedge clk_i) disable iff (!rstn_i)
        (state_q == flrwl_pkg::FLRWL_SQ_IDLE && !fire) |=>
            state_q == flrwl_pkg::FLRWL_SQ_IDLE && $stable(flash_words_o)
    ) else $error("Activity started without unlock");

    nop_pair_a: assert property ( // [R15]
        @(posedge clk_i) disable iff (!rstn_i)
        fire |=> force_nop_o [*2] ##1 !force_nop_o
    ) else $error("Not exactly two forced no-ops");

    stall_hold_a: assert property ( // [R15]
        @(posedge clk_i) disable iff (!rstn_i)
        (cpu_stall_o && !flash_done_i) |=> cpu_stall_o
    ) else $error("Stall dropped before flash done");

    word_form_a: assert property ( // [R16]
        @(posedge clk_i) disable iff (!rstn_i)
        load_now |=> flash_words_o[$past(latch_idx)] ==
            $past({prog_data_i.data_high[5:0], prog_data_i.data_low})
    ) else $error("Latch word badly formed");

    start_clear_a: assert property ( // [R17]
        @(posedge clk_i) disable iff (!rstn_i)
        (fire && latch_only_mode_i && !erase_select_i)
            |=> write_start_o ##1 write_start_o ##1 !write_start_o
    ) else $error("Start bit not cleared after latch load");

    cmd_hold_a: assert property ( // [R4]
        @(posedge clk_i) disable iff (!rstn_i)
        (flash_req_o && !flash_done_i) |=> $stable(flash_cmd_o)
    ) else $error("Flash command changed while requested");

    done_ignore_a: assert property ( // [R6]
        @(posedge clk_i) disable iff (!rstn_i)
        (flash_done_i && !flash_req_o && !load_now) |=>
            $stable(flash_words_o)
    ) else $error("Stray done touched the latches");

    erase_cmd_a: assert property ( // [R2]
        @(posedge clk_i) disable iff (!rstn_i)
        (fire && erase_select_i) |=>
            flash_cmd_o.op == flrwl_pkg::FLRWL_OP_ERASE ##2 flash_req_o
    ) else $error("Erase start did not issue a row erase");

    latch_only_mode_no_req_a: assert property ( // [R8]
        @(posedge clk_i) disable iff (!rstn_i)
        (fire && latch_only_mode_i && !erase_select_i) |=>
            !flash_req_o [*4]
    ) else $error("Latch-only unlock requested a flash write");

    stall_after_nop_a: assert property ( // [R15]
        @(posedge clk_i) disable iff (!rstn_i)
        (fire && !latch_only_mode_i) |-> ##3 (cpu_stall_o && !force_nop_o)
    ) else $error("Stall did not follow the two no-ops");

endmodule
`default_nettype wire

// ==== shared/flrwl_cfg.svh ====
// Constants for the flash row write latch block
// Assumes inclusion by the package and by the design modules
`ifndef FLRWL_CFG_SVH
`define FLRWL_CFG_SVH

// Latch array shape
`define FLRWL_LATCH_NUM 16
`define FLRWL_WORD_W 14
`define FLRWL_IDX_W 4

// Address split
`define FLRWL_ADDR_W 15
`define FLRWL_ROW_W 10
`define FLRWL_ROW_LSB 5

// Blank word value
`define FLRWL_BLANK 14'h3fff

// Unlock byte pattern
`define FLRWL_UNLOCK_A 8'h55
`define FLRWL_UNLOCK_B 8'haa

// Forced no-op count after the start bit
`define FLRWL_NOP_CYCLES 2

`endif

// ==== shared/flrwl_pkg.sv ====
// Types of the flash row write latch block
// Assumes the constants header is on the include path
`default_nettype none
`include "flrwl_cfg.svh"

package flrwl_pkg;

    typedef enum logic [1:0] {
        FLRWL_UL_IDLE  = 2'b00,
        FLRWL_UL_GOT_A = 2'b01,
        FLRWL_UL_ARMED = 2'b10
    } flrwl_unlock_e;

    typedef enum logic [1:0] {
        FLRWL_SQ_IDLE = 2'b00,
        FLRWL_SQ_NOP1 = 2'b01,
        FLRWL_SQ_NOP2 = 2'b10,
        FLRWL_SQ_WAIT = 2'b11
    } flrwl_seq_e;

    typedef enum logic [1:0] {
        FLRWL_OP_NONE  = 2'b00,
        FLRWL_OP_PROG  = 2'b01,
        FLRWL_OP_ERASE = 2'b10
    } flrwl_op_e;

    typedef struct packed {
        logic [6:0] addr_high;
        logic [7:0] addr_low;
    } flrwl_addr_s;

    typedef struct packed {
        logic [7:0] data_high;
        logic [7:0] data_low;
    } flrwl_data_s;

    typedef struct packed {
        flrwl_op_e op;
        logic cfg;
        logic [`FLRWL_ROW_W-1:0] row;
    } flrwl_flash_req_s;

endpackage
`default_nettype wire

// ==== hdl/flrwl_unlock.sv ====
// Unlock sequence detector: 55h, 0AAh, then start bit
// Assumes one CPU access per clock, strobes one cycle wide
`timescale 1ns/1ps
`default_nettype none
`include "flrwl_cfg.svh"

module flrwl_unlock (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rstn_i,
    // CPU accesses
    input wire logic unlock_wr_i,
    input wire logic [7:0] unlock_data_i,
    input wire logic other_wr_i,
    input wire logic start_i,
    input wire logic write_enable_bit_i,
    // Result
    output logic fire_o
);

    flrwl_pkg::flrwl_unlock_e state_q, state_d;
    logic fire_d;

    always_comb begin
        state_d = state_q;
        fire_d = 1'b0;
        // [R14] Exact byte order
        // [R10] Broken sequence aborts
        if (!write_enable_bit_i || other_wr_i) begin
            state_d = flrwl_pkg::FLRWL_UL_IDLE;
        end else if (unlock_wr_i) begin
            if (unlock_data_i == `FLRWL_UNLOCK_A) begin
                state_d = flrwl_pkg::FLRWL_UL_GOT_A;
            end else if (unlock_data_i == `FLRWL_UNLOCK_B &&
                         state_q == flrwl_pkg::FLRWL_UL_GOT_A) begin
                state_d = flrwl_pkg::FLRWL_UL_ARMED;
            end else begin
                state_d = flrwl_pkg::FLRWL_UL_IDLE;
            end
        end else if (start_i) begin
            // [R17] Ignored without write enable
            fire_d = (state_q == flrwl_pkg::FLRWL_UL_ARMED);
            state_d = flrwl_pkg::FLRWL_UL_IDLE;
        end
    end

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            state_q <= flrwl_pkg::FLRWL_UL_IDLE;
        end else begin
            state_q <= state_d;
        end
    end

    assign fire_o = fire_d;

    unlock_order_a: assert property ( // [R14]
        @(posedge clk_i) disable iff (!rstn_i)
        fire_o |-> state_q == flrwl_pkg::FLRWL_UL_ARMED && start_i &&
            !unlock_wr_i && !other_wr_i
    ) else $error("Unlock fired without full byte order");

    unlock_write_enable_bit_a: assert property ( // [R17]
        @(posedge clk_i) disable iff (!rstn_i)
        !write_enable_bit_i |-> !fire_o
    ) else $error("Unlock fired with writes disabled");

endmodule
`default_nettype wire

// ==== hdl/flrwl_latches.sv ====
// Row of program memory write latches held in flip-flops
// Assumes load and blank never coincide with a flash operation
`timescale 1ns/1ps
`default_nettype none
`include "flrwl_cfg.svh"

module flrwl_latches #(
    parameter int LATCH_NUM = `FLRWL_LATCH_NUM,
    parameter int WORD_W = `FLRWL_WORD_W,
    parameter int IDX_W = `FLRWL_IDX_W
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rstn_i,
    // Load and blank
    input wire logic load_i,
    input wire logic [IDX_W-1:0] idx_i,
    input wire logic [WORD_W-1:0] word_i,
    input wire logic blank_i,
    // Contents
    output logic [LATCH_NUM-1:0][WORD_W-1:0] words_o
);

    localparam int LATCHES_HI = LATCH_NUM - 1;

    logic [LATCHES_HI:0][WORD_W-1:0] words_q, words_d;

    always_comb begin
        // [R7] Unloaded latches hold
        words_d = words_q;
        // [R6] Blank after every operation
        if (blank_i) begin
            for (int i = 0; i < LATCH_NUM; i++) begin
                words_d[i] = WORD_W'(`FLRWL_BLANK);
            end
        end else if (load_i) begin
            words_d[idx_i] = word_i;
        end
    end

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            words_q <= {LATCH_NUM{WORD_W'(`FLRWL_BLANK)}};
        end else begin
            words_q <= words_d;
        end
    end

    assign words_o = words_q;

    latch_spare_a: assert property ( // [R7]
        @(posedge clk_i) disable iff (!rstn_i)
        (load_i && !blank_i && words_q[0] == WORD_W'(`FLRWL_BLANK)
            && idx_i != '0) |=> words_q[0] == WORD_W'(`FLRWL_BLANK)
    ) else $error("Unloaded latch lost its blank value");

endmodule
`default_nettype wire

// ==== verif/tb_top.sv ====
// Self-checking bench for the flash row write latch sequencer
// Assumes the package and constants header are compiled first
`timescale 1ns/1ps
`default_nettype none
`include "flrwl_cfg.svh"

`define CHK(got, exp) begin checks_done++; if ((got) !== (exp)) begin \
    n_fail++; $display("CHECK FAILED t=%0t got=%h exp=%h", $time, \
    got, exp); end end

module tb_top;
    logic clk_i;
    logic rstn_i;
    flrwl_pkg::flrwl_addr_s prog_addr_i;
    flrwl_pkg::flrwl_data_s prog_data_i;
    logic write_enable_bit_i;
    logic config_space_select_i;
    logic latch_only_mode_i;
    logic erase_select_i;
    logic unlock_wr_i;
    logic [7:0] unlock_data_i;
    logic other_wr_i;
    logic write_start_set_i;
    logic write_start_o;
    logic force_nop_o;
    logic cpu_stall_o;
    logic flash_req_o;
    flrwl_pkg::flrwl_flash_req_s flash_cmd_o;
    logic [15:0][13:0] flash_words_o;
    logic flash_done_i;
    logic [13:0] exp_w [16];
    logic [2:0] row3;
    logic [7:0] bad;
    int n_fail;
    int checks_done;
    int seed_v;

    flrwl_top dut (
        .clk_i(clk_i),
        .rstn_i(rstn_i),
        .prog_addr_i(prog_addr_i),
        .prog_data_i(prog_data_i),
        .write_enable_bit_i(write_enable_bit_i),
        .config_space_select_i(config_space_select_i),
        .latch_only_mode_i(latch_only_mode_i),
        .erase_select_i(erase_select_i),
        .unlock_wr_i(unlock_wr_i),
        .unlock_data_i(unlock_data_i),
        .other_wr_i(other_wr_i),
        .write_start_set_i(write_start_set_i),
        .write_start_o(write_start_o),
        .force_nop_o(force_nop_o),
        .cpu_stall_o(cpu_stall_o),
        .flash_req_o(flash_req_o),
        .flash_cmd_o(flash_cmd_o),
        .flash_words_o(flash_words_o),
        .flash_done_i(flash_done_i)
    );

    initial begin
        clk_i = 1'b0;
        forever #50 clk_i = ~clk_i;
    end

    // Expected latch word and row
    function automatic logic [13:0] word_of(flrwl_pkg::flrwl_data_s d);
        return {d.data_high[5:0], d.data_low};
    endfunction

    function automatic logic [9:0] row_of(flrwl_pkg::flrwl_addr_s a);
        return {a.addr_high, a.addr_low[7:5]};
    endfunction

    task automatic final_report();
        $display("Checks %0d, mismatches %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    task automatic check_words();
        for (int i = 0; i < 16; i++) begin
            `CHK(flash_words_o[i], exp_w[i])
        end
    endtask

    // First byte, second byte or abort, then start bit
    task automatic unlock(input logic [7:0] first, input bit abort);
        // Back to back, no interrupt between
        @(negedge clk_i);
        unlock_wr_i = 1'b1;
        unlock_data_i = first;
        @(negedge clk_i);
        if (abort) begin
            unlock_wr_i = 1'b0;
            other_wr_i = 1'b1;
        end else begin
            unlock_data_i = 8'haa;
        end
        @(negedge clk_i);
        unlock_wr_i = 1'b0;
        other_wr_i = 1'b0;
        write_start_set_i = 1'b1;
        @(negedge clk_i);
        write_start_set_i = 1'b0;
    endtask

    task automatic refuse(input logic [7:0] first, input bit abort);
        prog_data_i = 16'($urandom);
        unlock(first, abort);
        `CHK({write_start_o, force_nop_o, flash_req_o}, 3'b000)
        check_words();
        @(negedge clk_i);
        `CHK({write_start_o, force_nop_o, cpu_stall_o}, 3'b000)
    endtask

    task automatic load_one(input logic [3:0] idx, input logic b4);
        prog_addr_i.addr_low = {row3, b4, idx};
        prog_data_i = 16'($urandom);
        unlock(8'h55, 1'b0);
        exp_w[idx] = word_of(prog_data_i);
        `CHK(write_start_o, 1'b1)
        `CHK(force_nop_o, 1'b1)
        `CHK(flash_words_o[idx], exp_w[idx])
        @(negedge clk_i);
        `CHK(force_nop_o, 1'b1)
        @(negedge clk_i);
        `CHK(write_start_o, 1'b0)
        `CHK({force_nop_o, flash_req_o, cpu_stall_o}, 3'b000)
        check_words();
    endtask

    task automatic flash_op(input bit erase);
        logic [3:0] idx;
        flrwl_pkg::flrwl_op_e eop;
        idx = 4'($urandom);
        eop = erase ? flrwl_pkg::FLRWL_OP_ERASE : flrwl_pkg::FLRWL_OP_PROG;
        erase_select_i = erase;
        latch_only_mode_i = 1'b0;
        prog_addr_i.addr_low = {row3, 1'b0, idx};
        prog_data_i = 16'($urandom);
        unlock(8'h55, 1'b0);
        if (!erase) begin
            exp_w[idx] = word_of(prog_data_i);
        end
        `CHK(flash_req_o, 1'b0)
        `CHK(force_nop_o, 1'b1)
        check_words();
        @(negedge clk_i);
        `CHK(force_nop_o, 1'b1)
        @(negedge clk_i);
        `CHK(flash_req_o, 1'b1)
        `CHK({cpu_stall_o, force_nop_o}, 2'b10)
        `CHK(flash_cmd_o.op, eop)
        `CHK(flash_cmd_o.row, row_of(prog_addr_i))
        `CHK(flash_cmd_o.cfg, 1'b0)
        check_words();
        repeat (1 + $urandom % 16) @(negedge clk_i);
        `CHK({flash_req_o, cpu_stall_o, write_start_o}, 3'b111)
        flash_done_i = 1'b1;
        @(negedge clk_i);
        flash_done_i = 1'b0;
        `CHK({flash_req_o, cpu_stall_o, write_start_o}, 3'b000)
        for (int i = 0; i < 16; i++) begin
            exp_w[i] = `FLRWL_BLANK;
        end
        check_words();
        erase_select_i = 1'b0;
    endtask

    initial begin
        #(100 * 20000);
        n_fail++;
        final_report();
    end

    initial begin
        n_fail = 0;
        checks_done = 0;
        rstn_i = 1'b0;
        prog_addr_i = '0;
        prog_data_i = '0;
        write_enable_bit_i = 1'b0;
        config_space_select_i = 1'b0;
        latch_only_mode_i = 1'b1;
        erase_select_i = 1'b0;
        unlock_wr_i = 1'b0;
        unlock_data_i = 8'h00;
        other_wr_i = 1'b0;
        write_start_set_i = 1'b0;
        flash_done_i = 1'b0;
        row3 = 3'h0;
        for (int i = 0; i < 16; i++) begin
            exp_w[i] = `FLRWL_BLANK;
        end
        seed_v = $urandom(32'h70a911ce);
        repeat (12) @(posedge clk_i);
        @(negedge clk_i);
        rstn_i = 1'b1;
        // Blank after reset
        check_words();
        `CHK({write_start_o, force_nop_o, cpu_stall_o, flash_req_o}, 4'h0)
        write_enable_bit_i = 1'b1;
        refuse(8'haa, 1'b0);
        refuse(8'h55, 1'b1);
        bad = 8'($urandom);
        if (bad == 8'h55) begin
            bad = 8'h56;
        end
        refuse(bad, 1'b0);
        write_enable_bit_i = 1'b0;
        refuse(8'h55, 1'b0);
        write_enable_bit_i = 1'b1;
        for (int r = 0; r < 3; r++) begin
            latch_only_mode_i = 1'b1;
            prog_addr_i.addr_high = 7'($urandom);
            row3 = 3'($urandom);
            load_one(4'hf, 1'b1);
            repeat ($urandom % 5) load_one(4'($urandom % 15), 1'b0);
            flash_op(r == 1);
        end
        // Done outside a request is ignored
        flash_done_i = 1'b1;
        @(negedge clk_i);
        flash_done_i = 1'b0;
        `CHK({flash_req_o, cpu_stall_o, write_start_o}, 3'b000)
        check_words();
        // Mid-run reset blanks loaded latches
        latch_only_mode_i = 1'b1;
        load_one(4'($urandom), 1'b0);
        rstn_i = 1'b0;
        repeat (2) @(negedge clk_i);
        rstn_i = 1'b1;
        for (int i = 0; i < 16; i++) begin
            exp_w[i] = `FLRWL_BLANK;
        end
        check_words();
        `CHK({write_start_o, force_nop_o, cpu_stall_o, flash_req_o}, 4'h0)
        load_one(4'h3, 1'b0);
        final_report();
    end
endmodule

`default_nettype wire
